// [rtl/mfr_decoder.sv]
// multi-line fast read front end: opcode, address, mode, dummy and data
// phases for the quad output, dual i/o and quad i/o read families.
// assumes a byte memory on clk_in answering within two cycles of a read
// strobe, and a serial clock far slower than clk_in (sampled, not clocked).
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - opcode 6Bh returns data four bits per clock on all four io lines.
// - quad output read accepted only while quad_io_enable is one.
// - 6Bh: opcode, 24-bit address, eight ignored dummy clocks, then data.
// - BBh takes the address two bits per clock, returns data on two lines.
// - dual/quad i/o reads carry an 8-bit mode field after the address.
// - only the upper mode nibble decides opcode skipping; lower is ignored.
// - mode Ax on BBh: next select cycle starts directly with the address.
// - any other mode value: next select cycle expects an opcode again.
// - EBh uses four lines after the opcode with four dummy clocks before data.
// - quad i/o read runs only while quad_io_enable is set.
// - mode Ax on EBh: next read skips the opcode.
// - E7h needs address bit zero clear and two dummy clocks.
// - word quad read runs only while quad_io_enable is set.
// - mode Ax on E7h: next read skips the opcode.
// - E3h needs low four address bits clear, data right after mode.
// - octal word quad read runs only while quad_io_enable is set.
// - mode Ax on E3h: next read skips the opcode.
// - address steps up after each byte so data streams on.
// - reads arriving while busy are ignored and leave that cycle alone.
module mfr_decoder (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic select_bar_in,
  input wire logic [3:0] serial_io_lines_in,
  input wire logic quad_io_enable_in,
  input wire logic busy_in,
  input wire logic [7:0] mem_data_in,
  output logic [3:0] serial_io_lines_out,
  output logic [3:0] serial_io_lines_oe_out,
  output mfr_pkg::mfr_mem_req_type mem_req_out,
  output logic execute_in_place_out
);

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;

  // io, select and serial clock all share one sync depth so they stay aligned
  mfr_pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in({sclk_in, select_bar_in, serial_io_lines_in}),
    .rst_val_in(6'h3F),
    .lvl_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  wire logic [3:0] io_s = pin_lvl[3:0];
  wire logic sel_high = pin_lvl[4];
  wire logic sel_fall = pin_fall[4];
  wire logic sck_rise = pin_rise[5] & ~pin_lvl[4];
  wire logic sck_fall = pin_fall[5] & ~pin_lvl[4];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  mfr_pkg::mfr_state_type st_q, st_d;
  mfr_pkg::mfr_kind_type kind_q, kind_d;
  mfr_pkg::mfr_kind_type crm_kind_q, crm_kind_d;
  logic crm_q, crm_d;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d;
  logic [7:0] byte_q, byte_d;
  logic [2:0] grp_q, grp_d;
  logic [3:0] io_q, io_d;
  logic [3:0] oe_q, oe_d;
  mfr_pkg::mfr_mem_req_type mem_q, mem_d;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  mfr_pkg::mfr_cfg_type cfg;
  mfr_pkg::mfr_cfg_type crm_cfg;
  mfr_pkg::mfr_kind_type opc_kind;
  mfr_pkg::mfr_cfg_type opc_cfg;
  logic [23:0] sh_next;
  logic [7:0] opc_byte;
  logic cnt_last;
  logic opc_refused;
  logic crm_refused;
  logic [7:0] out_byte;
  logic grp_last;

  assign cfg = mfr_pkg::cfg_of(kind_q);
  assign crm_cfg = mfr_pkg::cfg_of(crm_kind_q);
  // lanes depend on the phase: opcode is single line, mode rides address lanes
  assign sh_next = mfr_pkg::shift_in(sh_q, io_s,
                                     (st_q == mfr_pkg::ST_OPC) ? mfr_pkg::LANE1 : cfg.addr_lane);
  assign opc_byte = sh_next[7:0];
  assign opc_kind = mfr_pkg::kind_of(opc_byte);
  assign opc_cfg = mfr_pkg::cfg_of(opc_kind);
  assign cnt_last = (cnt_q == mfr_pkg::CNT_LAST);
  // unsupported, busy, or quad without enable: drop the whole frame
  assign opc_refused = (opc_kind == mfr_pkg::KIND_NONE) || busy_in
                       || (opc_cfg.needs_quad && !quad_io_enable_in);
  assign crm_refused = busy_in
                       || (crm_cfg.needs_quad && !quad_io_enable_in);
  // a fresh byte is taken from memory at the first group of each byte
  assign out_byte = (grp_q == mfr_pkg::GRP_ZERO) ? mem_data_in : byte_q;
  assign grp_last = (grp_q == mfr_pkg::last_grp(cfg.data_lane));

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // one sampled serial edge at most per cycle; select high overrides all
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    crm_kind_d = crm_kind_q;
    crm_d = crm_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    byte_d = byte_q;
    grp_d = grp_q;
    io_d = io_q;
    oe_d = oe_q;
    mem_d = mem_q;
    mem_d.rd = 1'b0;
    if (sel_high) begin
      st_d = mfr_pkg::ST_IDLE;
      oe_d = mfr_pkg::OE_NONE;
    end else if (sel_fall) begin
      sh_d = '0;
      if (crm_q) begin
        // continuous mode: the frame opens straight into the address
        kind_d = crm_kind_q;
        cnt_d = mfr_pkg::clocks_of(mfr_pkg::ADDR_BITS, crm_cfg.addr_lane);
        st_d = crm_refused ? mfr_pkg::ST_SKIP : mfr_pkg::ST_ADDR;
      end else begin
        cnt_d = mfr_pkg::OPC_BITS;
        st_d = mfr_pkg::ST_OPC;
      end
    end else if (sck_rise) begin
      case (st_q)
        mfr_pkg::ST_OPC: begin
          sh_d = sh_next;
          cnt_d = cnt_q - mfr_pkg::CNT_STEP;
          if (cnt_last) begin
            kind_d = opc_kind;
            sh_d = '0;
            cnt_d = mfr_pkg::clocks_of(mfr_pkg::ADDR_BITS, opc_cfg.addr_lane);
            st_d = opc_refused ? mfr_pkg::ST_SKIP : mfr_pkg::ST_ADDR;
          end
        end
        mfr_pkg::ST_ADDR: begin
          sh_d = sh_next;
          cnt_d = cnt_q - mfr_pkg::CNT_STEP;
          if (cnt_last) begin
            // low address bits are forced clear for the word forms
            mem_d.addr = sh_next & cfg.addr_mask;
            if (cfg.has_mode) begin
              cnt_d = mfr_pkg::clocks_of(mfr_pkg::MODE_BITS, cfg.addr_lane);
              st_d = mfr_pkg::ST_MODE;
            end else begin
              cnt_d = {1'b0, cfg.dummy};
              st_d = mfr_pkg::ST_DUMMY;
            end
          end
        end
        mfr_pkg::ST_MODE: begin
          sh_d = sh_next;
          cnt_d = cnt_q - mfr_pkg::CNT_STEP;
          if (cnt_last) begin
            // only the upper nibble counts; the lower one is don't care
            crm_d = (sh_next[7:4] == mfr_pkg::CRM_ARM_NIBBLE);
            crm_kind_d = kind_q;
            cnt_d = {1'b0, cfg.dummy};
            if (cfg.dummy == mfr_pkg::DUMMY_NONE) begin
              st_d = mfr_pkg::ST_DATA;
              mem_d.rd = 1'b1;
              grp_d = mfr_pkg::GRP_ZERO;
            end else begin
              st_d = mfr_pkg::ST_DUMMY;
            end
          end
        end
        mfr_pkg::ST_DUMMY: begin
          // io inputs are ignored; only the clocks are counted
          cnt_d = cnt_q - mfr_pkg::CNT_STEP;
          if (cnt_last) begin
            st_d = mfr_pkg::ST_DATA;
            mem_d.rd = 1'b1;
            grp_d = mfr_pkg::GRP_ZERO;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end else if (sck_fall && (st_q == mfr_pkg::ST_DATA)) begin
      // drive on the falling edge, top bits of the byte first
      if (cfg.data_lane == mfr_pkg::LANE2) begin
        io_d = {2'b00, out_byte[7:6]};
        oe_d = mfr_pkg::OE_DUAL;
        byte_d = {out_byte[5:0], 2'b00};
      end else begin
        io_d = out_byte[7:4];
        oe_d = mfr_pkg::OE_QUAD;
        byte_d = {out_byte[3:0], 4'h0};
      end
      grp_d = grp_q + mfr_pkg::GRP_STEP;
      if (grp_last) begin
        // prefetch the next byte so it is ready at the next group zero
        grp_d = mfr_pkg::GRP_ZERO;
        mem_d.addr = mem_q.addr + mfr_pkg::ADDR_STEP;
        mem_d.rd = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  // every output is one of these flops; clock enable low holds them all
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= mfr_pkg::ST_IDLE;
      kind_q <= mfr_pkg::KIND_NONE;
      crm_kind_q <= mfr_pkg::KIND_NONE;
      crm_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      byte_q <= '0;
      grp_q <= '0;
      io_q <= '0;
      oe_q <= mfr_pkg::OE_NONE;
      mem_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
      kind_q <= kind_d;
      crm_kind_q <= crm_kind_d;
      crm_q <= crm_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      grp_q <= grp_d;
      io_q <= io_d;
      oe_q <= oe_d;
      mem_q <= mem_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign serial_io_lines_out = io_q;
  assign serial_io_lines_oe_out = oe_q;
  assign mem_req_out = mem_q;
  assign execute_in_place_out = crm_q;

endmodule // mfr_decoder
`default_nettype wire

// [rtl/mfr_pin_sync.sv]
// two-flop synchroniser with edge detection for the serial pins.
// assumes pins are asynchronous to clk_in; edges come from the second stage.
`timescale 1ns/100ps
`default_nettype none

module mfr_pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rst_val_in,
  output logic [WIDTH-1:0] lvl_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // ----------------------------------------
  // synchroniser chain
  // ----------------------------------------
  // reset value is all ones so a select held high looks idle at release
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else if (ce_in) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges only from stage two onward, never from the first flop
  assign lvl_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;

endmodule // mfr_pin_sync
`default_nettype wire

// [rtl/mfr_pkg.sv]
// package for the multi-line fast read decoder: opcodes, phase lengths,
// lane codes, state and command types, decode functions.
// assumes a 24-bit flash address and a byte-wide memory behind the block.
package mfr_pkg;

  // ----------------------------------------
  // opcodes and field constants
  // ----------------------------------------
  localparam logic [7:0] OPC_QOUT = 8'h6B;
  localparam logic [7:0] OPC_DIO = 8'hBB;
  localparam logic [7:0] OPC_QIO = 8'hEB;
  localparam logic [7:0] OPC_WQIO = 8'hE7;
  localparam logic [7:0] OPC_OWQIO = 8'hE3;
  localparam logic [4:0] OPC_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] MODE_BITS = 5'h08;
  localparam logic [3:0] CRM_ARM_NIBBLE = 4'hA;
  localparam logic [3:0] DUMMY_QOUT = 4'h8;
  localparam logic [3:0] DUMMY_QIO = 4'h4;
  localparam logic [3:0] DUMMY_WQIO = 4'h2;
  localparam logic [3:0] DUMMY_NONE = 4'h0;
  localparam logic [23:0] MASK_ALL = 24'hFFFFFF;
  localparam logic [23:0] MASK_WORD = 24'hFFFFFE;
  localparam logic [23:0] MASK_OCTWORD = 24'hFFFFF0;
  localparam logic [23:0] ADDR_STEP = 24'h000001;
  localparam logic [4:0] CNT_LAST = 5'h01;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam logic [2:0] GRP_STEP = 3'h1;
  localparam logic [2:0] GRP_ZERO = 3'h0;

  // lane codes: log2 of the number of io lines used per clock
  localparam logic [1:0] LANE1 = 2'h0;
  localparam logic [1:0] LANE2 = 2'h1;
  localparam logic [1:0] LANE4 = 2'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [3:0] OE_NONE = 4'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPC = 7'h02,
    ST_ADDR = 7'h04,
    ST_MODE = 7'h08,
    ST_DUMMY = 7'h10,
    ST_DATA = 7'h20,
    ST_SKIP = 7'h40
  } mfr_state_type;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_QOUT = 3'h1,
    KIND_DIO = 3'h2,
    KIND_QIO = 3'h3,
    KIND_WQIO = 3'h4,
    KIND_OWQIO = 3'h5
  } mfr_kind_type;

  typedef struct packed {
    logic [1:0] addr_lane;
    logic [1:0] data_lane;
    logic has_mode;
    logic needs_quad;
    logic [3:0] dummy;
    logic [23:0] addr_mask;
  } mfr_cfg_type;

  typedef struct packed {
    logic rd;
    logic [23:0] addr;
  } mfr_mem_req_type;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic mfr_kind_type kind_of(input logic [7:0] opc);
    mfr_kind_type k;
    k = KIND_NONE;
    if (opc == OPC_QOUT) k = KIND_QOUT;
    else if (opc == OPC_DIO) k = KIND_DIO;
    else if (opc == OPC_QIO) k = KIND_QIO;
    else if (opc == OPC_WQIO) k = KIND_WQIO;
    else if (opc == OPC_OWQIO) k = KIND_OWQIO;
    return k;
  endfunction

  function automatic mfr_cfg_type cfg_of(input mfr_kind_type k);
    mfr_cfg_type c;
    c = '{LANE4, LANE4, 1'b1, 1'b1, DUMMY_QIO, MASK_ALL};
    case (k)
      KIND_QOUT: c = '{LANE1, LANE4, 1'b0, 1'b1, DUMMY_QOUT, MASK_ALL};
      KIND_DIO: c = '{LANE2, LANE2, 1'b1, 1'b0, DUMMY_NONE, MASK_ALL};
      KIND_WQIO: c = '{LANE4, LANE4, 1'b1, 1'b1, DUMMY_WQIO, MASK_WORD};
      KIND_OWQIO: c = '{LANE4, LANE4, 1'b1, 1'b1, DUMMY_NONE, MASK_OCTWORD};
      default: c = '{LANE4, LANE4, 1'b1, 1'b1, DUMMY_QIO, MASK_ALL};
    endcase
    return c;
  endfunction

  // clocks needed to carry a field of the given width on the given lanes
  function automatic logic [4:0] clocks_of(input logic [4:0] bits, input logic [1:0] lane);
    return bits >> lane;
  endfunction

  // shift in the lanes in use, highest line holding the more significant bit
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input logic [1:0] lane);
    logic [23:0] r;
    r = {sh[22:0], io[0]};
    case (lane)
      LANE2: r = {sh[21:0], io[1:0]};
      LANE4: r = {sh[19:0], io[3:0]};
      default: r = {sh[22:0], io[0]};
    endcase
    return r;
  endfunction

  // number of output groups in one byte minus one
  function automatic logic [2:0] last_grp(input logic [1:0] lane);
    return 3'h7 >> lane;
  endfunction

endpackage

// [verif/mfr_decoder_properties.sv]
// port checks for the fast read decoder
// assumes qe and busy only change while select has long been high
`timescale 1ns/100ps
`default_nettype none

module mfr_decoder_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic select_bar_in,
  input wire logic quad_io_enable_in,
  input wire logic busy_in,
  input wire logic [3:0] serial_io_lines_oe_out,
  input wire mfr_pkg::mfr_mem_req_type mem_req_out,
  input wire logic execute_in_place_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic [3:0] oe = serial_io_lines_oe_out;
  wire logic drv = (oe != 4'h0);
  logic [23:0] prev_q;
  logic seen_q;

  // last read address of this frame, forgotten at select high
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_q <= 24'h0;
      seen_q <= 1'b0;
    end else if (select_bar_in) begin
      seen_q <= 1'b0;
    end else if (mem_req_out.rd) begin
      prev_q <= mem_req_out.addr;
      seen_q <= 1'b1;
    end
  end

  a_oe_shape: assert property (oe == 4'h0 || oe == 4'h3 || oe == 4'hF)
    else $error("output enable not none, dual or quad");
  a_release_end: assert property (select_bar_in [*6] |-> oe == 4'h0)
    else $error("io still driven after select high");
  a_quad_gate: assert property (oe == 4'hF |-> quad_io_enable_in)
    else $error("quad drive while quad disabled");
  a_busy_gate: assert property ($rose(drv) |-> !busy_in)
    else $error("drive started while busy");
  a_first_drive: assert property ($rose(drv) |-> !sclk_in && !select_bar_in)
    else $error("drive started outside a clock low phase");
  a_rd_pulse: assert property (mem_req_out.rd |=> !mem_req_out.rd)
    else $error("read strobe longer than one cycle");
  a_rd_frame: assert property (mem_req_out.rd |-> !select_bar_in && !busy_in)
    else $error("read strobe outside an accepted frame");
  a_addr_step: assert property (mem_req_out.rd && seen_q |-> mem_req_out.addr == prev_q + 24'h1)
    else $error("read address did not step by one");
  a_mode_frame: assert property (!$stable(execute_in_place_out) |-> !select_bar_in)
    else $error("continuous mode changed outside a frame");
endmodule // mfr_decoder_props

`default_nettype wire

// [verif/mfr_host_model.sv]
// host controller model: mode 0 serial clock, select and io lines
// assumes the bench resolves the shared io wire and returns it on io_in
`timescale 1ns/100ps
`default_nettype none

module mfr_host_model (
  input wire logic [3:0] io_in,
  output var logic sclk_out,
  output var logic select_bar_out,
  output var logic [3:0] io_out,
  output var logic [3:0] oe_out
);
  // idle: clock parked low between frames, lines released
  initial begin
    sclk_out = 1'b0;
    select_bar_out = 1'b1;
    io_out = 4'h0;
    oe_out = 4'h0;
  end

  task automatic sel_low();
    select_bar_out = 1'b0;
    #125;
  endtask

  // gap after select covers the decoder's enable drop
  task automatic sel_high();
    #125 select_bar_out = 1'b1;
    oe_out = 4'h0;
    #250;
  endtask

  // n clocks on w lines, top bits first; drv 0 off, 1 on, 2 on then release
  task automatic shift(input logic [31:0] v, input int n, input int w, input int drv,
                       output logic [31:0] r);
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      oe_out = (drv != 0) ? 4'((1 << w) - 1) : 4'h0;
      io_out = 4'(v[31:28] >> (4 - w));
      v = v << w;
      #62.5 sclk_out = 1'b1;
      #40 r = (r << w) | 32'(io_in & 4'((1 << w) - 1));
      // release before the fall that may carry first data
      if (drv == 2 && i == n - 1) oe_out = 4'h0;
      #22.5 sclk_out = 1'b0;
    end
  endtask
endmodule // mfr_host_model

`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the fast read decoder
// assumes the host model drives the pins; memory answers half a cycle after rd
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk_in = 1'b0;
  logic nrst = 1'b0;
  logic qe = 1'b1;
  logic busy = 1'b0;
  logic ce = 1'b1;
  logic execute_in_place;
  logic seen = 1'b0;
  logic [7:0] mem_data = 8'h00;
  logic [3:0] h_io, h_oe, d_io, d_oe, io_w;
  logic [3:0] io_q = 4'h0;
  logic sclk, sel_bar;
  mfr_pkg::mfr_mem_req_type req;
  logic [7:0] ops [5] = '{8'h6B, 8'hBB, 8'hEB, 8'hE7, 8'hE3};
  int fail_count = 0;
  int checks_done = 0;

  // 100 MHz system clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // undriven lines show the inverse of last level, no pull on them
  assign io_w = (h_oe & h_io) | (~h_oe & d_oe & d_io) | (~h_oe & ~d_oe & ~io_q);
  always @(posedge clk_in) io_q <= io_w;
  always @(posedge clk_in) if (d_oe != 4'h0) seen = 1'b1;
  always @(negedge clk_in) if (req.rd) mem_data <= pat(req.addr);

  mfr_host_model i_mfr_host_model (.io_in(io_w), .sclk_out(sclk),
    .select_bar_out(sel_bar), .io_out(h_io), .oe_out(h_oe));
  mfr_decoder i_mfr_decoder (.clk_in(clk_in), .nrst_in(nrst), .ce_in(ce),
    .sclk_in(sclk), .select_bar_in(sel_bar), .serial_io_lines_in(io_w),
    .quad_io_enable_in(qe), .busy_in(busy), .mem_data_in(mem_data),
    .serial_io_lines_out(d_io), .serial_io_lines_oe_out(d_oe),
    .mem_req_out(req), .execute_in_place_out(execute_in_place));

  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one read frame; ok says whether the decoder should answer
  task automatic rd_frame(input logic [7:0] opc, input logic [23:0] a, input logic [7:0] m,
                          input bit skip, input bit ok);
    int aw, dw, dm;
    logic [23:0] ea;
    logic [31:0] r;
    logic xe;
    aw = 4;
    dw = 4;
    dm = 0;
    ea = a;
    case (opc)
      8'h6B: begin aw = 1; dm = 8; end
      8'hBB: begin aw = 2; dw = 2; end
      8'hEB: dm = 4;
      8'hE7: begin dm = 2; ea[0] = 1'b0; end
      8'hE3: ea[3:0] = 4'h0;
      default: ;
    endcase
    xe = ok ? (opc != 8'h6B && m[7:4] == 4'hA) : execute_in_place;
    seen = 1'b0;
    i_mfr_host_model.sel_low();
    if (!skip) i_mfr_host_model.shift({opc, 24'h0}, 8, 1, 1, r);
    i_mfr_host_model.shift({a, 8'h0}, 24 / aw, aw, (opc == 8'h6B) ? 2 : 1, r);
    if (opc != 8'h6B) i_mfr_host_model.shift({m, 24'h0}, 8 / aw, aw, 2, r);
    if (dm > 0) i_mfr_host_model.shift(32'h0, dm, aw, 0, r);
    i_mfr_host_model.shift(32'h0, 16 / dw, dw, 0, r);
    i_mfr_host_model.sel_high();
    if (ok) chk("data", {pat(ea), pat(ea + 24'h1)}, r[15:0]);
    chk("drive", 16'(ok), 16'(seen));
    chk("xip", 16'(xe), 16'(execute_in_place));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reads();
    foreach (ops[i]) rd_frame(ops[i], 24'h0A0F37, 8'h00, 1'b0, 1'b1);
  endtask

  // arm, skip with low nibble changed, skip then disarm, normal again
  task automatic t_cont();
    for (int i = 1; i < 5; i++) begin
      rd_frame(ops[i], 24'h100200, 8'hA5, 1'b0, 1'b1);
      rd_frame(ops[i], 24'h3000F0, 8'hA0, 1'b1, 1'b1);
      rd_frame(ops[i], 24'h000010, 8'h5A, 1'b1, 1'b1);
      rd_frame(ops[i], 24'h000020, 8'h00, 1'b0, 1'b1);
    end
  endtask

  task automatic t_refuse();
    @(negedge clk_in) qe = 1'b0;
    foreach (ops[i]) if (i != 1) rd_frame(ops[i], 24'h000040, 8'hA5, 1'b0, 1'b0);
    rd_frame(8'hBB, 24'h000050, 8'h00, 1'b0, 1'b1);
    @(negedge clk_in) qe = 1'b1;
    rd_frame(8'h03, 24'h000060, 8'hA5, 1'b0, 1'b0);
    @(negedge clk_in) busy = 1'b1;
    rd_frame(8'hEB, 24'h000070, 8'hA5, 1'b0, 1'b0);
    @(negedge clk_in) busy = 1'b0;
    rd_frame(8'hEB, 24'h000080, 8'hA5, 1'b0, 1'b1);
    @(negedge clk_in) busy = 1'b1;
    rd_frame(8'hEB, 24'h000090, 8'h00, 1'b1, 1'b0);
    @(negedge clk_in) busy = 1'b0;
    rd_frame(8'hEB, 24'h0000A0, 8'h00, 1'b1, 1'b1);
  endtask

  // clock enable low holds state; reset in mid-run drops continuous mode and drive
  task automatic t_reset();
    rd_frame(8'hBB, 24'h0000B0, 8'hA5, 1'b0, 1'b1);
    @(negedge clk_in) ce = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("xip held", 16'h1, 16'(execute_in_place));
    ce = 1'b1;
    @(negedge clk_in) nrst = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("xip reset", 16'h0, 16'(execute_in_place));
    chk("oe reset", 16'h0, 16'(d_oe));
    nrst = 1'b1;
    repeat (4) @(negedge clk_in);
    rd_frame(8'hBB, 24'h0000C0, 8'h00, 1'b0, 1'b1);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // run is some 115 us of link traffic; stop well after that
  initial begin
    #600000;
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in) nrst = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("xip idle", 16'h0, 16'(execute_in_place));
    t_reads();
    t_cont();
    t_refuse();
    t_reset();
    wrap_up();
  end
endmodule // tb_top

bind mfr_decoder mfr_decoder_props i_mfr_decoder_props (.clk_in(clk_in), .nrst_in(nrst_in),
  .sclk_in(sclk_in), .select_bar_in(select_bar_in), .quad_io_enable_in(quad_io_enable_in),
  .busy_in(busy_in), .serial_io_lines_oe_out(serial_io_lines_oe_out),
  .mem_req_out(mem_req_out), .execute_in_place_out(execute_in_place_out));

`default_nettype wire
